// File: hw/dual_dac_serial_write_port.sv
/*
 * Serial write port of a dual-channel converter. The shift-clock domain
 * assembles 24-bit frames; a toggle carries each finished word into the
 * system clock domain, where a two-entry buffer feeds the register logic.
 * Assumes the host keeps frame sync high at least several system clocks
 * between frames and that core_ready comes from logic on clk.
 */
`timescale 1ns/1ns
module dual_dac_serial_write_port
	import dac_port_pkg::*;
#(
	parameter int RES       = 16,
	parameter bit MID_SCALE = 1'b0
) (
	// System clock
	input  logic            clk,
	input  logic            rst,
	input  logic            ce,
	// Serial link
	input  logic            sclk,
	input  logic            frame_sync_n,
	input  logic            sdi,
	// Control pins
	input  logic            load_outputs_n,
	input  logic            async_clear_n,
	// Converter core
	input  logic            core_ready,
	output logic [RES-1:0]  out_code_a,
	output logic [RES-1:0]  out_code_b,
	output logic            clear_mode,
	output logic            overrun
);

	localparam logic [RES-1:0] RST_CODE = RES'(reset_code(RES, MID_SCALE));

	// Shift-clock domain.
	logic                   link_clr;
	logic [4:0]             bit_cnt_reg, bit_cnt_next;
	logic [FRAME_BITS-1:0]  shift_reg, shift_next;
	frame_word_t            word_hold_reg, word_hold_next;
	logic                   done_tgl_reg, done_tgl_next;
	logic                   last_edge;

	// Frame sync high holds the counter clear, so a short frame never
	// reaches the last edge and its bits are simply forgotten.
	assign link_clr  = frame_sync_n | rst;
	assign last_edge = (bit_cnt_reg == LAST_BIT);

	always_comb begin
		bit_cnt_next   = bit_cnt_reg;
		shift_next     = {shift_reg[FRAME_BITS-2:0], sdi};
		word_hold_next = word_hold_reg;
		done_tgl_next  = done_tgl_reg;
		if (bit_cnt_reg != FRAME_END)
			bit_cnt_next = bit_cnt_reg + 5'h01;
		if (last_edge) begin
			word_hold_next = frame_word_t'(shift_next);
			done_tgl_next  = ~done_tgl_reg;
		end
	end

	always_ff @(negedge sclk or posedge link_clr) begin
		if (link_clr) begin
			bit_cnt_reg <= 5'h00;
			shift_reg   <= '0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			shift_reg   <= shift_next;
		end
	end

	// Word and toggle survive frame sync so the other domain can read them.
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			word_hold_reg <= '0;
			done_tgl_reg  <= 1'b0;
		end else begin
			word_hold_reg <= word_hold_next;
			done_tgl_reg  <= done_tgl_next;
		end
	end

	// System clock domain: synchronisers and edge detection.
	logic [3:0]  pins_raw;
	logic [3:0]  pins_s1_reg, pins_s1_next;
	logic [3:0]  pins_s2_reg, pins_s2_next;
	logic [3:0]  pins_s3_reg, pins_s3_next;
	logic        frame_active, frame_start;
	logic        ld_low, ld_fall, clr_fall, word_rx;

	assign pins_raw = {frame_sync_n, load_outputs_n, async_clear_n,
		done_tgl_reg};

	always_comb begin
		pins_s1_next = pins_s1_reg;
		pins_s2_next = pins_s2_reg;
		pins_s3_next = pins_s3_reg;
		if (ce) begin
			pins_s1_next = pins_raw;
			pins_s2_next = pins_s1_reg;
			pins_s3_next = pins_s2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pins_s1_reg <= PIN_IDLE;
			pins_s2_reg <= PIN_IDLE;
			pins_s3_reg <= PIN_IDLE;
		end else begin
			pins_s1_reg <= pins_s1_next;
			pins_s2_reg <= pins_s2_next;
			pins_s3_reg <= pins_s3_next;
		end
	end

	assign frame_active = ~pins_s2_reg[PIN_FS];
	assign frame_start  = pins_s3_reg[PIN_FS] & ~pins_s2_reg[PIN_FS];
	assign ld_low       = ~pins_s2_reg[PIN_LD];
	assign ld_fall      = ce & pins_s3_reg[PIN_LD] & ~pins_s2_reg[PIN_LD];
	assign clr_fall     = ce & pins_s3_reg[PIN_CLR] & ~pins_s2_reg[PIN_CLR];
	assign word_rx      = ce & (pins_s3_reg[PIN_TGL] ^ pins_s2_reg[PIN_TGL]);

	// Word buffer between the link and the register logic.
	logic         abort_reg, abort_next;
	logic         buf_in_valid, buf_in_ready;
	logic         buf_out_valid, buf_out_ready;
	frame_word_t  buf_out_data;
	logic         pop;

	assign buf_in_valid  = word_rx & ~abort_reg & ~clr_fall;
	assign buf_out_ready = core_ready & ~clr_fall;
	assign pop           = ce & buf_out_valid & buf_out_ready;

	two_entry_buffer #(
		.W ($bits(frame_word_t))
	) u_buf (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.flush     (clr_fall),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (word_hold_reg),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// Channel registers.
	logic [RES-1:0]  in_a_reg, in_a_next;
	logic [RES-1:0]  in_b_reg, in_b_next;
	logic [RES-1:0]  out_a_reg, out_a_next;
	logic [RES-1:0]  out_b_reg, out_b_next;
	logic            clear_mode_reg, clear_mode_next;
	logic            overrun_reg, overrun_next;
	logic            load_pend_reg, load_pend_next;
	logic [RES-1:0]  pop_code;
	logic            cmd_ok, sel_a, sel_b;
	logic            upd_now, load_go;

	assign pop_code = buf_out_data.data[15 -: RES];
	assign cmd_ok   = (buf_out_data.cmd == CMD_WRITE) |
		(buf_out_data.cmd == CMD_WRITE_UPDATE);
	assign sel_a    = (buf_out_data.chan == CHAN_A) |
		(buf_out_data.chan == CHAN_BOTH);
	assign sel_b    = (buf_out_data.chan == CHAN_B) |
		(buf_out_data.chan == CHAN_BOTH);
	// A held-low load pin makes every accepted word update its outputs.
	assign upd_now  = ld_low | (buf_out_data.cmd == CMD_WRITE_UPDATE);
	// A load request waits until words already sent have been applied.
	assign load_go  = ce & load_pend_reg & ~buf_out_valid & ~word_rx;

	always_comb begin
		in_a_next       = in_a_reg;
		in_b_next       = in_b_reg;
		out_a_next      = out_a_reg;
		out_b_next      = out_b_reg;
		clear_mode_next = clear_mode_reg;
		overrun_next    = overrun_reg;
		abort_next      = abort_reg;
		load_pend_next  = load_pend_reg;
		if (ce) begin
			if (frame_start)
				abort_next = 1'b0;
			if (clr_fall & frame_active)
				abort_next = 1'b1;
			if (buf_in_valid & ~buf_in_ready)
				overrun_next = 1'b1;
			if (load_go)
				load_pend_next = 1'b0;
			if (ld_fall)
				load_pend_next = 1'b1;
			if (pop & cmd_ok) begin
				clear_mode_next = 1'b0;
				if (sel_a)
					in_a_next = pop_code;
				if (sel_b)
					in_b_next = pop_code;
				if (upd_now & sel_a)
					out_a_next = pop_code;
				if (upd_now & sel_b)
					out_b_next = pop_code;
			end
			if (load_go) begin
				out_a_next = in_a_next;
				out_b_next = in_b_next;
			end
			if (clr_fall) begin
				in_a_next       = RST_CODE;
				in_b_next       = RST_CODE;
				out_a_next      = RST_CODE;
				out_b_next      = RST_CODE;
				clear_mode_next = 1'b1;
				load_pend_next  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			in_a_reg       <= RST_CODE;
			in_b_reg       <= RST_CODE;
			out_a_reg      <= RST_CODE;
			out_b_reg      <= RST_CODE;
			clear_mode_reg <= 1'b0;
			overrun_reg    <= 1'b0;
			abort_reg      <= 1'b0;
			load_pend_reg  <= 1'b0;
		end else begin
			in_a_reg       <= in_a_next;
			in_b_reg       <= in_b_next;
			out_a_reg      <= out_a_next;
			out_b_reg      <= out_b_next;
			clear_mode_reg <= clear_mode_next;
			overrun_reg    <= overrun_next;
			abort_reg      <= abort_next;
			load_pend_reg  <= load_pend_next;
		end
	end

	assign out_code_a = out_a_reg;
	assign out_code_b = out_b_reg;
	assign clear_mode = clear_mode_reg;
	assign overrun    = overrun_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_clear_edge;
		clr_fall;
	endsequence

	sequence s_good_pop_a;
		pop & cmd_ok & sel_a & ~clr_fall;
	endsequence

	a_clear_loads_code: assert property (s_clear_edge |=>
		(out_code_a == RST_CODE) && (out_code_b == RST_CODE) &&
		(in_a_reg == RST_CODE) && clear_mode)
		else $error("clear did not load the reset code");
	a_clear_mode_exit: assert property (s_good_pop_a |=> !clear_mode)
		else $error("clear-code mode not left after a write");
	a_abort_drops_word: assert property (abort_reg && word_rx |->
		!buf_in_valid ##1 !pop [*1])
		else $error("aborted word entered the buffer");
	a_sync_mode_update: assert property ((s_good_pop_a and ld_low) |=>
		out_code_a == $past(pop_code))
		else $error("synchronous update did not reach output");
	a_code_into_input: assert property (s_good_pop_a |=>
		in_a_reg == $past(pop_code))
		else $error("channel code not taken as straight binary");
	a_async_load_both: assert property (load_go && !clr_fall |=>
		(out_code_a == in_a_reg) && (out_code_b == in_b_reg))
		else $error("load edge did not copy both channels");
	a_load_served: assert property (ld_fall && !clr_fall && !buf_out_valid
		&& !word_rx ##1 ce && !buf_out_valid && !word_rx && !clr_fall |=>
		!load_pend_reg)
		else $error("load request left waiting");
	a_reset_code: assert property (@(posedge clk)
		$fell(rst) |-> (out_code_a == RST_CODE) && (out_code_b == RST_CODE))
		else $error("outputs not at reset code after reset");
	// The check lands on the first edge of the next frame, so only reset
	// may cancel it; frame sync going high in between must not.
	a_frame_complete: assert property (@(negedge sclk)
		disable iff (rst) last_edge && !link_clr |=>
		done_tgl_reg != $past(done_tgl_reg))
		else $error("24th edge did not finish the word");
	a_partial_silent: assert property (@(negedge sclk)
		disable iff (link_clr) bit_cnt_reg < LAST_BIT |=>
		done_tgl_reg == $past(done_tgl_reg))
		else $error("word finished before 24 edges");
	a_msb_first: assert property (@(negedge sclk)
		disable iff (rst) last_edge && !link_clr |=>
		word_hold_reg[0] == $past(sdi))
		else $error("last sampled bit is not the word's LSB");

endmodule

// File: hw/dac_port_pkg.sv
/*
 * Shared constants and types for the dual-channel converter serial write
 * port: frame geometry, the chosen layout of the 24-bit word, the index of
 * each pin in the synchroniser vector and the reset-code helper.
 * Assumes the main module and the bench import the whole package; the buffer does not use it.
 */
// Function
// - While frame sync is low, sample data on each falling shift-clock edge.
// - Shift one data bit into a 24-bit register per falling edge in a frame.
// - Frame sync rising before the 24th falling edge drops the word.
// - Synchronous mode: outputs update at the 24th falling edge of a frame; the code updates them on clk when the word leaves the buffer.
// - Load pin falling edge copies all input registers to outputs together.
// - Clear falling edge loads the reset code into all channel registers.
// - Clear-code mode lasts until the 24th falling edge of the next write; the code leaves it on clk when a valid write leaves the buffer.
// - Clear during a serial write aborts that write.
// - Channel code is straight binary of 12, 14 or 16 bits.
package dac_port_pkg;

	localparam int          FRAME_BITS = 24;
	localparam logic [4:0]  LAST_BIT   = 5'(FRAME_BITS - 1);
	localparam logic [4:0]  FRAME_END  = 5'(FRAME_BITS);

	localparam logic [3:0]  CMD_WRITE        = 4'h0;
	localparam logic [3:0]  CMD_WRITE_UPDATE = 4'h1;
	localparam logic [3:0]  CHAN_A           = 4'h0;
	localparam logic [3:0]  CHAN_B           = 4'h1;
	localparam logic [3:0]  CHAN_BOTH        = 4'hF;

	localparam int          PIN_FS   = 3;
	localparam int          PIN_LD   = 2;
	localparam int          PIN_CLR  = 1;
	localparam int          PIN_TGL  = 0;
	localparam logic [3:0]  PIN_IDLE = 4'hE;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [3:0]  chan;
		logic [15:0] data;
	} frame_word_t;

	function automatic logic [15:0] reset_code(input int res, input bit mid);
		logic [15:0] code;
		code = 16'h0000;
		if (mid)
			code = 16'(1 << (res - 1));
		return code;
	endfunction

endpackage

// File: hw/two_entry_buffer.sv
/*
 * Two-entry first-in first-out buffer with valid and ready on both sides.
 * Assumes a single clock, synchronous active-high reset and a clock enable
 * that freezes all state; flush empties it in one cycle.
 */
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int W = 24
) (
	// Clock and control
	input  logic          clk,
	input  logic          rst,
	input  logic          ce,
	input  logic          flush,
	// Fill side
	input  logic          in_valid,
	output logic          in_ready,
	input  logic [W-1:0]  in_data,
	// Drain side
	output logic          out_valid,
	input  logic          out_ready,
	output logic [W-1:0]  out_data
);

	logic [W-1:0]  ent0_reg, ent0_next;
	logic [W-1:0]  ent1_reg, ent1_next;
	logic [1:0]    cnt_reg, cnt_next;
	logic          push;
	logic          pop;
	logic [1:0]    cnt_after;

	assign in_ready  = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = ent0_reg;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		ent0_next = ent0_reg;
		ent1_next = ent1_reg;
		cnt_next  = cnt_reg;
		cnt_after = cnt_reg - {1'b0, pop};
		if (ce) begin
			if (pop)
				ent0_next = ent1_reg;
			if (push) begin
				if (cnt_after == 2'h0)
					ent0_next = in_data;
				else
					ent1_next = in_data;
			end
			cnt_next = cnt_after + {1'b0, push};
			if (flush)
				cnt_next = 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ent0_reg <= '0;
			ent1_reg <= '0;
			cnt_reg  <= 2'h0;
		end else begin
			ent0_reg <= ent0_next;
			ent1_reg <= ent1_next;
			cnt_reg  <= cnt_next;
		end
	end

endmodule

// File: tb/link_host.sv
/*
 * Host-side model of the serial write link: frame sync, shift clock, data.
 * Assumes callers space frames apart; the shift clock idles high.
 */
`timescale 1ns/1ns
module link_host (
	// Serial link
	output logic sclk,
	output logic frame_sync_n,
	output logic sdi
);
	initial begin
		sclk = 1'b1;
		frame_sync_n = 1'b1;
		sdi = 1'b0;
	end

	// Sends the first n bits of w at a 20 ns shift period.
	task automatic frame(input logic [23:0] w, input int n);
		frame_sync_n = 1'b0;
		#13;
		for (int i = 0; i < n; i++) begin
			sdi = w[23 - i];
			#10 sclk = 1'b0;
			#10 sclk = 1'b1;
		end
		sdi = ~sdi;
		#10 frame_sync_n = 1'b1;
		#90;
	endtask
endmodule

// File: tb/dual_dac_serial_write_port_tb_top.sv
/*
 * Self-checking bench for the serial write port.
 * Assumes the 16-bit zero-scale variant and the host model in link_host.
 */
`timescale 1ns/1ns
module dual_dac_serial_write_port_tb_top;
	import dac_port_pkg::*;
	logic        clk;
	logic        rst;
	logic        ce;
	logic        sclk;
	logic        frame_sync_n;
	logic        sdi;
	logic        load_outputs_n;
	logic        async_clear_n;
	logic        core_ready;
	logic [15:0] out_code_a;
	logic [15:0] out_code_b;
	logic        clear_mode;
	logic        overrun;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	link_host host_u (
		.sclk        (sclk),
		.frame_sync_n(frame_sync_n),
		.sdi         (sdi)
	);

	dual_dac_serial_write_port #(.RES(16), .MID_SCALE(1'b0)) dut_u (
		.clk           (clk),
		.rst           (rst),
		.ce            (ce),
		.sclk          (sclk),
		.frame_sync_n  (frame_sync_n),
		.sdi           (sdi),
		.load_outputs_n(load_outputs_n),
		.async_clear_n (async_clear_n),
		.core_ready    (core_ready),
		.out_code_a    (out_code_a),
		.out_code_b    (out_code_b),
		.clear_mode    (clear_mode),
		.overrun       (overrun)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end

	task automatic results();
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic frame_word_t wd(logic [3:0] c, ch, logic [15:0] d);
		return '{c, ch, d};
	endfunction

	task automatic send(input frame_word_t f, input int n);
		host_u.frame(f, n);
		repeat (10) @(posedge clk);
	endtask

	task automatic t_reset();
		chk("code_a", out_code_a, 16'h0000);
		chk("code_b", out_code_b, 16'h0000);
		chk("clear_mode", {15'h0, clear_mode}, 16'h0000);
		chk("overrun", {15'h0, overrun}, 16'h0000);
	endtask

	task automatic t_sync();
		send(wd(CMD_WRITE_UPDATE, CHAN_A, 16'hA5C3), 24);
		chk("code_a", out_code_a, 16'hA5C3);
		send(wd(CMD_WRITE_UPDATE, CHAN_BOTH, 16'h8001), 24);
		chk("code_a", out_code_a, 16'h8001);
		chk("code_b", out_code_b, 16'h8001);
	endtask

	task automatic t_abort();
		send(wd(CMD_WRITE_UPDATE, CHAN_B, 16'h0F0F), 22);
		chk("code_b", out_code_b, 16'h8001);
		send(wd(4'h2, CHAN_B, 16'h0F0F), 24);
		chk("code_b", out_code_b, 16'h8001);
		send(wd(CMD_WRITE_UPDATE, 4'h5, 16'h0F0F), 24);
		chk("code_a", out_code_a, 16'h8001);
		chk("code_b", out_code_b, 16'h8001);
	endtask

	task automatic t_async();
		@(posedge clk) load_outputs_n <= 1'b1;
		repeat (4) @(posedge clk);
		send(wd(CMD_WRITE, CHAN_A, 16'h1111), 24);
		send(wd(CMD_WRITE, CHAN_B, 16'h2222), 24);
		chk("code_a", out_code_a, 16'h8001);
		chk("code_b", out_code_b, 16'h8001);
		@(posedge clk) load_outputs_n <= 1'b0;
		repeat (3) @(posedge clk);
		load_outputs_n <= 1'b1;
		repeat (3) @(posedge clk);
		load_outputs_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("code_a", out_code_a, 16'h1111);
		chk("code_b", out_code_b, 16'h2222);
	endtask

	task automatic t_clear();
		@(posedge clk) async_clear_n <= 1'b0;
		repeat (4) @(posedge clk);
		async_clear_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("code_a", out_code_a, 16'h0000);
		chk("code_b", out_code_b, 16'h0000);
		chk("clear_mode", {15'h0, clear_mode}, 16'h0001);
		fork
			host_u.frame(wd(CMD_WRITE_UPDATE, CHAN_A, 16'h7777), 24);
			begin
				repeat (10) @(posedge clk);
				async_clear_n <= 1'b0;
				repeat (4) @(posedge clk);
				async_clear_n <= 1'b1;
			end
		join
		repeat (10) @(posedge clk);
		chk("code_a", out_code_a, 16'h0000);
		chk("clear_mode", {15'h0, clear_mode}, 16'h0001);
		send(wd(CMD_WRITE_UPDATE, CHAN_A, 16'h4444), 24);
		chk("clear_mode", {15'h0, clear_mode}, 16'h0000);
		chk("code_a", out_code_a, 16'h4444);
	endtask

	task automatic t_overrun();
		@(posedge clk) core_ready <= 1'b0;
		for (int i = 1; i <= 3; i++)
			send(wd(CMD_WRITE_UPDATE, CHAN_A, 16'(i)), 24);
		chk("code_a", out_code_a, 16'h4444);
		chk("overrun", {15'h0, overrun}, 16'h0001);
		@(posedge clk) core_ready <= 1'b1;
		repeat (10) @(posedge clk);
		chk("code_a", out_code_a, 16'h0002);
	endtask

	// A clear pulse seen only while the enable is low must leave no trace.
	task automatic t_freeze();
		@(posedge clk) ce <= 1'b0;
		async_clear_n <= 1'b0;
		repeat (4) @(posedge clk);
		async_clear_n <= 1'b1;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		chk("code_a", out_code_a, 16'h0002);
		chk("clear_mode", {15'h0, clear_mode}, 16'h0000);
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		load_outputs_n = 1'b0;
		async_clear_n = 1'b1;
		core_ready = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_sync();
		t_abort();
		t_async();
		t_clear();
		t_overrun();
		t_freeze();
		results();
	end
endmodule
